// ---- shared/err_detect_pkg.sv ----
`default_nettype none
package err_detect_pkg;

    localparam int            SEQ_W            = 12;
    localparam int            DATA_W           = 64;
    localparam int            CPL_ERR_W        = 1;
    localparam int            CPL_TIMEOUT_BIT  = 0;
    localparam int            CMD_MEM_EN_BIT   = 1;
    localparam logic [11:0]   CMD_REG_OFFSET   = 12'h004;
    localparam int            REPLAY_NUM_W     = 2;
    localparam logic [1:0]    REPLAY_NUM_RST   = 2'h0;
    localparam logic [1:0]    REPLAY_NUM_LAST  = 2'h3;
    localparam logic [2:0]    CPL_STATUS_UR    = 3'h1;
    localparam logic [SEQ_W-1:0] SEQ_ONE       = 12'h001;

    typedef enum logic [2:0] {
        TLP_MEM,
        TLP_IO,
        TLP_CFG0,
        TLP_CFG1,
        TLP_CPL,
        TLP_MSG
    } tlp_kind_t;

    typedef struct packed {
        tlp_kind_t   kind;
        logic        wr;
        logic        locked;
        logic        addr64;
        logic [31:0] addr_hi;
        logic        bar_hit;
        logic [2:0]  func;
        logic [15:0] req_id;
        logic [7:0]  tag;
        logic        poisoned;
        logic        msg_ok;
        logic        non_posted;
    } tlp_hdr_t;

    typedef struct packed {
        logic [15:0] own_id;
        logic [7:0]  func_present;
        logic [15:0] command;
        logic        native_ep;
    } cfg_t;

    typedef struct packed {
        logic             lcrc_fail;
        logic             seq_err;
        logic             dllp_crc_fail;
        logic             replay_timeout;
        logic             replay_start;
        logic             ack_progress;
        logic             acknak_valid;
        logic [SEQ_W-1:0] acknowledged_sequence_number;
    } dll_evt_t;

    typedef struct packed {
        logic bad_tlp;
        logic bad_dllp;
        logic replay_timer;
        logic replay_rollover;
        logic dll_protocol;
        logic poisoned;
        logic unsupported;
        logic cpl_timeout;
    } err_t;

    typedef struct packed {
        logic corr;
        logic nonfatal;
        logic fatal;
    } sev_t;

    typedef struct packed {
        logic [15:0] req_id;
        logic [7:0]  tag;
        logic [2:0]  status;
    } cpl_req_t;

    localparam err_t     ERR_RST = '0;
    localparam sev_t     SEV_RST = '0;
    localparam cpl_req_t CPL_RST = '0;

endpackage
`default_nettype wire

// ---- rtl/tlp_ur_screen.sv ----
`timescale 1ns/1ps
`default_nettype none
module tlp_ur_screen
    import err_detect_pkg::*;
(
    input  wire err_detect_pkg::tlp_hdr_t hdr,
    input  wire err_detect_pkg::cfg_t     cfg,
    output logic                          ur
);

    logic mem_ur;

    always_comb begin
        mem_ur = (hdr.locked && !hdr.wr && cfg.native_ep)
               || (hdr.addr64 && hdr.addr_hi == 32'h0000_0000)
               || !hdr.bar_hit
               || !cfg.command[CMD_MEM_EN_BIT];
        unique case (hdr.kind)
            TLP_CFG0: begin
                ur = !cfg.func_present[hdr.func]
                   || (hdr.wr && hdr.poisoned);
            end
            TLP_CFG1: begin
                ur = 1'b1;
            end
            TLP_MSG: begin
                ur = !hdr.msg_ok;
            end
            TLP_CPL: begin
                ur = (hdr.req_id != cfg.own_id)
                   || (hdr.locked && cfg.native_ep);
            end
            TLP_MEM: begin
                ur = mem_ur;
            end
            TLP_IO: begin
                ur = !hdr.bar_hit;
            end
            // Undefined kind codes are never trusted
            default: begin
                ur = 1'b1;
            end
        endcase
    end

endmodule
`default_nettype wire

// ---- rtl/ur_cpl_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module ur_cpl_gen
    import err_detect_pkg::*;
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       launch,
    input  wire logic [15:0]                req_id,
    input  wire logic [7:0]                 tag,
    output logic                            cpl_valid,
    output err_detect_pkg::cpl_req_t        cpl,
    input  wire logic                       cpl_ready
);

    logic     valid_ff;
    logic     nxt_valid;
    cpl_req_t cpl_ff;
    cpl_req_t nxt_cpl;

    // One completion in flight; the caller holds off new packets while busy
    always_comb begin
        nxt_valid = valid_ff && !cpl_ready;
        nxt_cpl   = cpl_ff;
        if (launch) begin
            nxt_valid      = 1'b1;
            nxt_cpl.req_id = req_id;
            nxt_cpl.tag    = tag;
            nxt_cpl.status = CPL_STATUS_UR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            valid_ff <= 1'b0;
            cpl_ff   <= CPL_RST;
        end else begin
            valid_ff <= nxt_valid;
            cpl_ff   <= nxt_cpl;
        end
    end

    assign cpl_valid = valid_ff;
    assign cpl       = cpl_ff;

endmodule
`default_nettype wire

// ---- rtl/pcie_dll_tl_error_detect.sv ----
// How it works
// - Received TLP with LCRC failure or sequence error pulses correctable bad-TLP.
// - Received DLLP with CRC failure pulses correctable bad-DLLP.
// - Each replay timer expiry pulses correctable replay-timer error.
// - Replay attempt counter wrapping pulses correctable rollover error.
// - Ack/Nak sequence naming neither an outstanding TLP nor the last acknowledged one pulses fatal protocol error.
// - Poisoned TLP that passes screening pulses non-fatal error and is still forwarded.
// - Type 0 config to an absent function is unsupported.
// - Completion with foreign requester ID is unsupported.
// - Unsupported messages and any type 1 config are unsupported.
// - Native endpoint: locked memory reads and locked completions are unsupported.
// - 64-bit memory address with zero upper half is unsupported.
// - Memory or I/O missing every BAR is unsupported.
// - Memory request while memory space is disabled is unsupported.
// - Poisoned type 0 config write is unsupported.
// - Unsupported packets are dropped, never forwarded to the application.
// - Dropped non-posted unsupported request gets an UR completion.
// - Completion timeout on report bit 0 logs a non-fatal error.
`timescale 1ns/1ps
`default_nettype none
module pcie_dll_tl_error_detect
    import err_detect_pkg::*;
(
    input  wire logic                           clk_sys,
    input  wire logic                           rst_n,
    input  wire err_detect_pkg::cfg_t           cfg,
    input  wire err_detect_pkg::dll_evt_t       dll,
    input  wire logic [err_detect_pkg::SEQ_W-1:0] oldest_unacked_seq,
    input  wire logic [err_detect_pkg::SEQ_W-1:0] next_tx_seq,
    input  wire logic                           rx_valid,
    input  wire logic                           rx_sop,
    input  wire logic                           rx_eop,
    input  wire logic [err_detect_pkg::DATA_W-1:0] rx_data,
    input  wire err_detect_pkg::tlp_hdr_t       rx_hdr,
    output logic                                rx_ready,
    output logic                                app_valid,
    output logic                                app_sop,
    output logic                                app_eop,
    output logic [err_detect_pkg::DATA_W-1:0]   app_data,
    output err_detect_pkg::tlp_hdr_t            app_hdr,
    input  wire logic                           app_ready,
    input  wire logic [err_detect_pkg::CPL_ERR_W-1:0] cpl_err,
    output logic                                ur_cpl_valid,
    output err_detect_pkg::cpl_req_t            ur_cpl,
    input  wire logic                           ur_cpl_ready,
    output err_detect_pkg::err_t                err_pulse,
    output err_detect_pkg::sev_t                err_sev
);

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_FWD,
        RX_DROP
    } rx_state_t;

    rx_state_t             state_ff;
    rx_state_t             nxt_state;
    logic                  out_valid_ff;
    logic                  nxt_out_valid;
    logic                  out_sop_ff;
    logic                  nxt_out_sop;
    logic                  out_eop_ff;
    logic                  nxt_out_eop;
    logic [DATA_W-1:0]     out_data_ff;
    logic [DATA_W-1:0]     nxt_out_data;
    tlp_hdr_t              out_hdr_ff;
    tlp_hdr_t              nxt_out_hdr;
    err_t                  err_ff;
    err_t                  nxt_err;
    sev_t                  sev_ff;
    sev_t                  nxt_sev;
    logic [REPLAY_NUM_W-1:0] replay_num_ff;
    logic [REPLAY_NUM_W-1:0] nxt_replay_num;
    logic [REPLAY_NUM_W-1:0] replay_base;
    logic                  cpl_err_q_ff;
    logic                  nxt_cpl_err_q;
    logic                  hdr_ur;
    logic                  take;
    logic                  head;
    logic                  fwd_beat;
    logic                  launch;
    logic                  cpl_busy;
    logic                  seq_ok;
    logic [SEQ_W-1:0]      outstanding;
    logic [SEQ_W-1:0]      ack_dist;

    ////////////////////////////////////////////////////////////////////////
    // Header screening and UR completion

    tlp_ur_screen u_screen (
        .hdr (rx_hdr),
        .cfg (cfg),
        .ur  (hdr_ur)
    );

    ur_cpl_gen u_cpl (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .launch    (launch),
        .req_id    (rx_hdr.req_id),
        .tag       (rx_hdr.tag),
        .cpl_valid (cpl_busy),
        .cpl       (ur_cpl),
        .cpl_ready (ur_cpl_ready)
    );

    assign ur_cpl_valid = cpl_busy;

    // Stalls while a UR completion waits, so a second one is never lost
    assign rx_ready = (!out_valid_ff || app_ready) && !cpl_busy;
    assign take     = rx_valid && rx_ready;
    assign head     = take && rx_sop && state_ff == RX_IDLE;
    assign launch   = head && hdr_ur && rx_hdr.non_posted;

    ////////////////////////////////////////////////////////////////////////
    // Receive path: forward or drop whole packets

    always_comb begin
        nxt_state     = state_ff;
        nxt_out_valid = out_valid_ff && !app_ready;
        nxt_out_sop   = out_sop_ff;
        nxt_out_eop   = out_eop_ff;
        nxt_out_data  = out_data_ff;
        nxt_out_hdr   = out_hdr_ff;
        // Poisoned packets pass through; only screening failures drop
        fwd_beat = take && ((state_ff == RX_FWD) || (head && !hdr_ur));
        if (fwd_beat) begin
            nxt_out_valid = 1'b1;
            nxt_out_sop   = rx_sop;
            nxt_out_eop   = rx_eop;
            nxt_out_data  = rx_data;
            if (rx_sop) begin
                nxt_out_hdr = rx_hdr;
            end
        end
        unique case (state_ff)
            RX_IDLE: begin
                if (head && !rx_eop) begin
                    nxt_state = hdr_ur ? RX_DROP : RX_FWD;
                end
            end
            RX_FWD, RX_DROP: begin
                if (take && rx_eop) begin
                    nxt_state = RX_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff     <= RX_IDLE;
            out_valid_ff <= 1'b0;
            out_sop_ff   <= 1'b0;
            out_eop_ff   <= 1'b0;
            out_data_ff  <= '0;
            out_hdr_ff   <= '0;
        end else begin
            state_ff     <= nxt_state;
            out_valid_ff <= nxt_out_valid;
            out_sop_ff   <= nxt_out_sop;
            out_eop_ff   <= nxt_out_eop;
            out_data_ff  <= nxt_out_data;
            out_hdr_ff   <= nxt_out_hdr;
        end
    end

    assign app_valid = out_valid_ff;
    assign app_sop   = out_sop_ff;
    assign app_eop   = out_eop_ff;
    assign app_data  = out_data_ff;
    assign app_hdr   = out_hdr_ff;

    ////////////////////////////////////////////////////////////////////////
    // Error detection and severity

    // Duplicate acks of the last acknowledged TLP stay legal
    always_comb begin
        outstanding = SEQ_W'(next_tx_seq - oldest_unacked_seq);
        ack_dist    = SEQ_W'(next_tx_seq - SEQ_ONE - dll.acknowledged_sequence_number);
        seq_ok      = ack_dist <= outstanding;
    end

    always_comb begin
        replay_base    = dll.ack_progress ? REPLAY_NUM_RST : replay_num_ff;
        nxt_replay_num = dll.replay_start ? REPLAY_NUM_W'(replay_base + 2'h1) : replay_base;
        nxt_cpl_err_q  = cpl_err[CPL_TIMEOUT_BIT];
        nxt_err.bad_tlp         = dll.lcrc_fail || dll.seq_err;
        nxt_err.bad_dllp        = dll.dllp_crc_fail;
        nxt_err.replay_timer    = dll.replay_timeout;
        nxt_err.replay_rollover = dll.replay_start
                                && replay_base == REPLAY_NUM_LAST;
        nxt_err.dll_protocol    = dll.acknak_valid && !seq_ok;
        nxt_err.poisoned        = head && rx_hdr.poisoned && !hdr_ur;
        nxt_err.unsupported     = head && hdr_ur;
        nxt_err.cpl_timeout     = cpl_err[CPL_TIMEOUT_BIT]
                                && !cpl_err_q_ff;
        nxt_sev.corr     = nxt_err.bad_tlp || nxt_err.bad_dllp
                         || nxt_err.replay_timer || nxt_err.replay_rollover;
        nxt_sev.nonfatal = nxt_err.poisoned || nxt_err.unsupported
                         || nxt_err.cpl_timeout;
        nxt_sev.fatal    = nxt_err.dll_protocol;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            replay_num_ff <= REPLAY_NUM_RST;
            cpl_err_q_ff  <= 1'b0;
            err_ff        <= ERR_RST;
            sev_ff        <= SEV_RST;
        end else begin
            replay_num_ff <= nxt_replay_num;
            cpl_err_q_ff  <= nxt_cpl_err_q;
            err_ff        <= nxt_err;
            sev_ff        <= nxt_sev;
        end
    end

    assign err_pulse = err_ff;
    assign err_sev   = sev_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    bad_tlp_pulse_a: assert property (
        (dll.lcrc_fail || dll.seq_err) |=> err_pulse.bad_tlp && err_sev.corr)
        else $error("bad TLP not reported");

    bad_dllp_pulse_a: assert property (
        dll.dllp_crc_fail |=> err_pulse.bad_dllp && err_sev.corr)
        else $error("bad DLLP not reported");

    replay_timer_a: assert property (
        dll.replay_timeout |=> err_pulse.replay_timer && err_sev.corr)
        else $error("replay timeout not reported");

    replay_rollover_a: assert property (
        (dll.replay_start && !dll.ack_progress && replay_num_ff == REPLAY_NUM_LAST)
        |=> err_pulse.replay_rollover && replay_num_ff == REPLAY_NUM_RST)
        else $error("replay rollover missed");

    no_early_rollover_a: assert property (
        (replay_num_ff != REPLAY_NUM_LAST && !dll.ack_progress)
        |=> !err_pulse.replay_rollover)
        else $error("rollover before counter wrapped");

    dll_protocol_a: assert property (
        (dll.acknak_valid && outstanding != 12'hfff
         && dll.acknowledged_sequence_number == next_tx_seq)
        |=> err_pulse.dll_protocol && err_sev.fatal)
        else $error("stray ack sequence not flagged");

    poison_forward_a: assert property (
        (head && rx_hdr.poisoned && !hdr_ur)
        |=> err_pulse.poisoned && app_valid && app_sop && app_hdr.poisoned)
        else $error("poisoned TLP not reported and forwarded");

    cfg1_ur_a: assert property (
        (head && rx_hdr.kind == TLP_CFG1) |=> err_pulse.unsupported && err_sev.nonfatal)
        else $error("type 1 config not flagged");

    ur_drop_a: assert property (
        (head && hdr_ur) |=> app_valid == $past(out_valid_ff && !app_ready))
        else $error("unsupported packet forwarded");

    drop_hold_a: assert property (
        (state_ff == RX_DROP && take && !rx_sop)
        |=> app_valid == $past(out_valid_ff && !app_ready))
        else $error("dropped packet beat forwarded");

    ur_cpl_a: assert property (
        launch |=> ur_cpl_valid && ur_cpl.status == CPL_STATUS_UR
                   && ur_cpl.tag == $past(rx_hdr.tag) && !rx_ready)
        else $error("UR completion not issued");

    cpl_timeout_a: assert property (
        $rose(cpl_err[CPL_TIMEOUT_BIT]) |=> err_pulse.cpl_timeout ##1 !err_pulse.cpl_timeout)
        else $error("completion timeout not a single pulse");

    good_ack_a: assert property (
        (dll.acknak_valid && dll.acknowledged_sequence_number == SEQ_W'(next_tx_seq - SEQ_ONE))
        |=> !err_pulse.dll_protocol)
        else $error("newest ack flagged as stray");

    foreign_cpl_a: assert property (
        (head && rx_hdr.kind == TLP_CPL && rx_hdr.req_id != cfg.own_id)
        |=> err_pulse.unsupported && err_sev.nonfatal && !app_valid)
        else $error("foreign completion not dropped");

    ur_cpl_hold_a: assert property (
        (ur_cpl_valid && !ur_cpl_ready) |=> ur_cpl_valid && $stable(ur_cpl))
        else $error("UR completion dropped before taken");

    ur_cover_c: cover property (launch ##1 ur_cpl_valid ##[1:4] ur_cpl_ready);
    poison_cover_c: cover property (head && rx_hdr.poisoned && !hdr_ur && !rx_eop);
    rollover_cover_c: cover property (err_pulse.replay_rollover);
    fatal_cover_c: cover property (err_sev.fatal);
    drop_cover_c: cover property (state_ff == RX_DROP ##1 state_ff == RX_IDLE);

endmodule
`default_nettype wire

// ---- tb/app_side_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module app_side_model
    import err_detect_pkg::*;
#(
    parameter int LIMIT = 20
)(
    input  wire logic                            clk_sys,
    input  wire logic                            rst_n,
    input  wire logic                            slow,
    input  wire logic                            start_req,
    input  wire logic                            app_valid,
    input  wire logic                            app_sop,
    input  wire err_detect_pkg::tlp_hdr_t        app_hdr,
    output logic                                 app_ready = 1'b1,
    input  wire logic                            ur_cpl_valid,
    output logic                                 ur_cpl_ready = 1'b0,
    output logic [err_detect_pkg::CPL_ERR_W-1:0] cpl_err = '0,
    output int                                   pkt_count = 0,
    output int                                   poison_count = 0
);
    int wait_ff = 0;
    int hold_ff = 0;
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            app_ready <= 1'b1;
            ur_cpl_ready <= 1'b0;
            cpl_err <= '0;
            wait_ff <= 0;
            hold_ff <= 0;
        end else begin
            // Slow mode stalls every other cycle to exercise back-pressure
            app_ready <= slow ? ~app_ready : 1'b1;
            ur_cpl_ready <= slow ? ~ur_cpl_ready : 1'b1;
            if (app_valid && app_ready && app_sop) begin
                pkt_count <= pkt_count + 1;
                if (app_hdr.poisoned) begin
                    poison_count <= poison_count + 1;
                end
            end
            if (start_req) begin
                wait_ff <= LIMIT;
            end else if (wait_ff > 1) begin
                wait_ff <= wait_ff - 1;
            end else if (wait_ff == 1) begin
                wait_ff <= 0;
                hold_ff <= 3;
            end
            if (hold_ff > 0) begin
                hold_ff <= hold_ff - 1;
            end
            // Held as a level for several cycles; only the rise may count
            cpl_err[CPL_TIMEOUT_BIT] <= (hold_ff > 0);
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; $display("Error %0t: got %0h want %0h", $time, a, b); end end
module tb_top;
    import err_detect_pkg::*;
    localparam sev_t     CORR  = '{corr:1'b1, default:'0};
    localparam sev_t     NONF  = '{nonfatal:1'b1, default:'0};
    localparam sev_t     FATAL = '{fatal:1'b1, default:'0};
    localparam err_t     URE   = '{unsupported:1'b1, default:'0};
    localparam err_t     POIS  = '{poisoned:1'b1, default:'0};
    localparam err_t     TMO   = '{cpl_timeout:1'b1, default:'0};
    localparam err_t     DLP   = '{dll_protocol:1'b1, default:'0};
    localparam dll_evt_t START = '{replay_start:1'b1, default:'0};
    localparam tlp_hdr_t BASE  = '{kind:TLP_MEM, wr:1'b1, bar_hit:1'b1, req_id:16'h0100, msg_ok:1'b1, default:'0};
    localparam tlp_hdr_t UR_TAB [11] = '{
        '{kind:TLP_CFG0, func:3'h3, non_posted:1'b1, default:'0},
        '{kind:TLP_CPL, req_id:16'h0200, default:'0},
        '{kind:TLP_MSG, default:'0},
        '{kind:TLP_CFG1, non_posted:1'b1, default:'0},
        '{kind:TLP_MEM, locked:1'b1, bar_hit:1'b1, non_posted:1'b1, default:'0},
        '{kind:TLP_CPL, locked:1'b1, req_id:16'h0100, default:'0},
        '{kind:TLP_MEM, addr64:1'b1, bar_hit:1'b1, non_posted:1'b1, default:'0},
        '{kind:TLP_MEM, wr:1'b1, default:'0},
        '{kind:TLP_IO, wr:1'b1, non_posted:1'b1, default:'0},
        '{kind:TLP_MEM, bar_hit:1'b1, non_posted:1'b1, default:'0},
        '{kind:TLP_CFG0, wr:1'b1, poisoned:1'b1, non_posted:1'b1, default:'0}
    };
    logic             clk_sys    = 1'b0;
    logic             rst_n      = 1'b0;
    cfg_t             cfg        = '{own_id:16'h0100, func_present:8'h01, command:16'h0002, native_ep:1'b1};
    dll_evt_t         dll        = '0;
    logic [SEQ_W-1:0] oldest_seq = 12'h00a;
    logic [SEQ_W-1:0] next_seq   = 12'h00f;
    logic             rx_valid   = 1'b0;
    logic             rx_sop     = 1'b0;
    logic             rx_eop     = 1'b0;
    logic [DATA_W-1:0] rx_data   = '0;
    tlp_hdr_t         rx_hdr     = '0;
    logic             slow       = 1'b0;
    logic             start_req  = 1'b0;
    logic             rx_ready, app_valid, app_sop, app_eop, app_ready, ur_cpl_valid, ur_cpl_ready;
    logic [DATA_W-1:0] app_data, last_data;
    tlp_hdr_t         app_hdr;
    logic [CPL_ERR_W-1:0] cpl_err;
    cpl_req_t         ur_cpl, last_cpl;
    err_t             err_pulse, seen_err;
    sev_t             err_sev, seen_sev;
    int               pkt_count, poison_count;
    int               bad_count = 0;
    int               cmp_count = 0;
    int               n_pulse = 0;
    int               n_cpl = 0;
    int               cyc = 0;

    pcie_dll_tl_error_detect u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg), .dll(dll),
        .oldest_unacked_seq(oldest_seq), .next_tx_seq(next_seq), .rx_valid(rx_valid), .rx_sop(rx_sop),
        .rx_eop(rx_eop), .rx_data(rx_data), .rx_hdr(rx_hdr), .rx_ready(rx_ready), .app_valid(app_valid),
        .app_sop(app_sop), .app_eop(app_eop), .app_data(app_data), .app_hdr(app_hdr), .app_ready(app_ready),
        .cpl_err(cpl_err), .ur_cpl_valid(ur_cpl_valid), .ur_cpl(ur_cpl), .ur_cpl_ready(ur_cpl_ready),
        .err_pulse(err_pulse), .err_sev(err_sev));
    app_side_model u_app (.clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .start_req(start_req),
        .app_valid(app_valid), .app_sop(app_sop), .app_hdr(app_hdr), .app_ready(app_ready),
        .ur_cpl_valid(ur_cpl_valid), .ur_cpl_ready(ur_cpl_ready), .cpl_err(cpl_err),
        .pkt_count(pkt_count), .poison_count(poison_count));

    always #12.5 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky error view plus a hang guard of 5000 cycles
    always @(posedge clk_sys) begin
        seen_err = seen_err | err_pulse;
        seen_sev = seen_sev | err_sev;
        if (err_pulse !== ERR_RST) n_pulse++;
        if (ur_cpl_valid && ur_cpl_ready) begin
            n_cpl++;
            last_cpl = ur_cpl;
        end
        if (app_valid && app_ready && app_eop) last_data = app_data;
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic clr;
        seen_err = ERR_RST;
        seen_sev = SEV_RST;
        n_pulse = 0;
    endtask

    // One link event, answer exactly one cycle later, gone the cycle after
    task automatic ev(input dll_evt_t d, input err_t e, input sev_t s);
        dll = d;
        tick;
        dll = '0;
        `CHK(err_pulse, e)
        `CHK(err_sev, s)
        tick;
        `CHK(err_pulse, ERR_RST)
    endtask

    // Two-beat packet; each beat held until an edge with rx_ready high
    task automatic send(input tlp_hdr_t h);
        rx_hdr = h;
        rx_valid = 1'b1;
        rx_sop = 1'b1;
        rx_data = 64'h0123456789abcdef;
        while (rx_ready !== 1'b1) tick;
        tick;
        rx_sop = 1'b0;
        rx_eop = 1'b1;
        rx_data = ~rx_data;
        while (rx_ready !== 1'b1) tick;
        tick;
        rx_valid = 1'b0;
        rx_eop = 1'b0;
        for (int k = 0; k < 40 && (ur_cpl_valid !== 1'b0 || app_valid !== 1'b0); k++) tick;
        tick;
    endtask

    task automatic t_link;
        ev('{lcrc_fail:1'b1, default:'0}, '{bad_tlp:1'b1, default:'0}, CORR);
        ev('{seq_err:1'b1, default:'0}, '{bad_tlp:1'b1, default:'0}, CORR);
        ev('{dllp_crc_fail:1'b1, default:'0}, '{bad_dllp:1'b1, default:'0}, CORR);
        ev('{replay_timeout:1'b1, default:'0}, '{replay_timer:1'b1, default:'0}, CORR);
    endtask

    // Two starts, then an ack must reset the count so rollover needs four more
    task automatic t_replay;
        ev(START, ERR_RST, SEV_RST);
        ev(START, ERR_RST, SEV_RST);
        ev('{ack_progress:1'b1, default:'0}, ERR_RST, SEV_RST);
        for (int k = 0; k < 3; k++) ev(START, ERR_RST, SEV_RST);
        ev(START, '{replay_rollover:1'b1, default:'0}, CORR);
    endtask

    task automatic ack(input logic [SEQ_W-1:0] q, input logic bad);
        dll_evt_t d;
        d = '{acknak_valid:1'b1, default:'0};
        d.acknowledged_sequence_number = q;
        ev(d, bad ? DLP : ERR_RST, bad ? FATAL : SEV_RST);
    endtask

    task automatic t_poison;
        tlp_hdr_t h;
        int       f0;
        int       p0;
        h = BASE;
        f0 = pkt_count;
        p0 = poison_count;
        clr();
        send(h);
        `CHK(n_pulse, 0)
        h.poisoned = 1'b1;
        slow = 1'b1;
        send(h);
        slow = 1'b0;
        `CHK(seen_err, POIS)
        `CHK(seen_sev, NONF)
        `CHK(n_pulse, 1)
        `CHK(pkt_count, f0 + 2)
        `CHK(poison_count, p0 + 1)
        `CHK(last_data, ~64'h0123456789abcdef)
    endtask

    // Every unsupported case, alternating a stalling application side
    task automatic t_ur;
        tlp_hdr_t h;
        int       f0;
        int       c0;
        for (int i = 0; i < 11; i++) begin
            h = UR_TAB[i];
            h.tag = 8'(i);
            cfg.command[CMD_MEM_EN_BIT] = (i != 9);
            slow = i[0];
            f0 = pkt_count;
            c0 = n_cpl;
            clr();
            send(h);
            `CHK(seen_err, URE)
            `CHK(seen_sev, NONF)
            `CHK(pkt_count, f0)
            `CHK(n_cpl, c0 + int'(h.non_posted))
            if (h.non_posted) `CHK(last_cpl, cpl_req_t'({h.req_id, h.tag, CPL_STATUS_UR}))
        end
        slow = 1'b0;
        cfg.native_ep = 1'b0;
        clr();
        send(UR_TAB[4]);
        `CHK(seen_err, ERR_RST)
        cfg.native_ep = 1'b1;
    endtask

    task automatic t_timeout;
        clr();
        start_req = 1'b1;
        tick;
        start_req = 1'b0;
        for (int k = 0; k < 60 && seen_err === ERR_RST; k++) tick;
        repeat (6) tick;
        `CHK(seen_err, TMO)
        `CHK(seen_sev, NONF)
        `CHK(n_pulse, 1)
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        tick;
        t_link();
        t_replay();
        ack(12'h00e, 1'b0);
        ack(12'h009, 1'b0);
        ack(12'h008, 1'b1);
        ack(12'h00f, 1'b1);
        t_poison();
        t_ur();
        t_timeout();
        complete_run();
    end
endmodule
`default_nettype wire
